// *** zone_two_guard_pkg.sv ***
// Constants, address map and encodings of the zone-two access guard
`default_nettype none
package zone_two_guard_pkg;
    // Link bit address space
    localparam int unsigned       ADDR_W            = 10;
    localparam logic [9:0]        ZONE2_BASE        = 10'h1C0;
    localparam logic [9:0]        ZONE2_LAST        = 10'h2BF;
    localparam logic [9:0]        PERMIT_WRITE_ADDR = 10'h1E0;
    localparam logic [9:0]        PERMIT_READ_ADDR  = 10'h1E1;
    localparam logic [9:0]        COUNTER_BASE      = 10'h2C0;
    localparam logic [9:0]        COUNTER_LAST      = 10'h33F;
    localparam logic [9:0]        TEST_BASE         = 10'h340;
    localparam logic [9:0]        TEST_LAST         = 10'h34F;
    localparam int unsigned       ZONE2_BITS        = 256;
    localparam int unsigned       COUNTER_BITS      = 128;
    localparam int unsigned       TEST_BITS         = 16;
    localparam int unsigned       KEY_BITS          = 32;

    // Register byte offsets on the bus
    localparam logic [7:0]        OFF_CTRL          = 8'h00;
    localparam logic [7:0]        OFF_STATUS        = 8'h04;
    localparam logic [7:0]        OFF_KEY           = 8'h08;
    localparam logic [7:0]        OFF_KEY_CHECK     = 8'h0C;
    localparam logic [7:0]        OFF_FUSE          = 8'h10;

    // Field positions
    localparam int unsigned       CTRL_END_SESSION  = 0;
    localparam int unsigned       ST_CODE_OK_BIT    = 0;
    localparam int unsigned       ST_KEY_OK_BIT     = 1;
    localparam int unsigned       ST_MODE2_BIT      = 2;
    localparam int unsigned       ST_FUSE_BIT       = 3;
    localparam int unsigned       ST_ARMED_BIT      = 4;
    localparam int unsigned       ST_REFUSED_BIT    = 5;
    localparam int unsigned       ST_COUNT_LSB      = 8;
    localparam int unsigned       FUSE_BIT          = 0;

    // Reset values and a bus transfer-type constant
    localparam logic [31:0]       KEY_RESET         = 32'h0000_0000;
    localparam logic              FUSE_RESET        = 1'b1;
    localparam logic              HTRANS_NONSEQ_BIT = 1'b1;

    typedef enum logic [1:0] {
        OP_READ  = 2'h0,
        OP_WRITE = 2'h1,
        OP_ERASE = 2'h2
    } link_op_e;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_LATCH = 3'h2,
        ST_EXEC  = 3'h4
    } guard_state_e;
endpackage
`default_nettype wire

// *** zone_two_access_guard.sv ***
// Zone-two access guard: link request handling, permission checks, bus registers
// What this block does
// - Bit 480 gates zone writes, bit 481 gates zone reads.
// - Level one with code verified: erasing any zone bit erases whole zone.
// - Erase-limit fuse at one enables counting, at most 128 zone erases.
// - Erase-limit fuse at zero: no erase cap, counter contents ignored.
// - Erase-limit fuse changeable only before the issuer fuse is blown.
// - Level one: single-bit zone writes allowed once code is verified.
// - Level two: zone writes also need the write-permit bit at one.
// - Zone reads granted when read-permit bit or code-verified flag is one.
// - 32-bit erase key, written only in level one after code verification.
// - Level two zone erase needs code and erase key both verified.
// - Matching erase key presentation sets the erase-key-verified flag.
// - Counter active only in mode two with fuse at one.
// - Reader clears one set counter bit before each counted zone erase.
// - With all counter bits cleared and the last arming used, no further zone erase is granted.
// - Counter bits may be written to zero but never erased.
// - Test zone read, write and erase always allowed.
// - Code verification sets the code-verified flag gating zone access.
// - Issuer fuse at one selects mode one, at zero mode two.
`timescale 1ns/1ps
`default_nettype none
module zone_two_access_guard (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic [31:0]      hrdata_out,
    input  wire logic        issuer_fuse_in,
    input  wire logic        code_verify_in,
    input  wire logic        link_clk_in,
    input  wire logic        link_req_in,
    input  wire logic [1:0]  link_op_in,
    input  wire logic [9:0]  link_addr_in,
    output logic             link_busy_out,
    output logic             link_done_out,
    output logic             link_grant_out,
    output logic             link_rdata_out
);
    localparam logic [9:0] WR_OFF = zone_two_guard_pkg::PERMIT_WRITE_ADDR - zone_two_guard_pkg::ZONE2_BASE;
    localparam logic [9:0] RD_OFF = zone_two_guard_pkg::PERMIT_READ_ADDR - zone_two_guard_pkg::ZONE2_BASE;

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: capture one request, hold it until the answer returns
    logic        l_busy_r;
    logic        l_req_tgl_r;
    logic [1:0]  l_op_r;
    logic [9:0]  l_addr_r;
    logic        l_ack_s1_r;
    logic        l_ack_s2_r;
    logic        l_ack_seen_r;
    logic        l_done_r;
    logic        l_grant_r;
    logic        l_rdata_r;
    logic        s_ack_tgl_r;
    logic        s_grant_r;
    logic        s_rdata_r;

    always_ff @(posedge link_clk_in or posedge rst_in) begin
        if (rst_in) begin
            l_ack_s1_r <= 1'b0;
            l_ack_s2_r <= 1'b0;
        end else begin
            l_ack_s1_r <= s_ack_tgl_r;
            l_ack_s2_r <= l_ack_s1_r;
        end
    end

    // Op and address stay put while busy, so the other domain reads them safely
    always_ff @(posedge link_clk_in or posedge rst_in) begin
        if (rst_in) begin
            l_busy_r     <= 1'b0;
            l_req_tgl_r  <= 1'b0;
            l_op_r       <= 2'h0;
            l_addr_r     <= 10'h000;
            l_ack_seen_r <= 1'b0;
            l_done_r     <= 1'b0;
            l_grant_r    <= 1'b0;
            l_rdata_r    <= 1'b0;
        end else begin
            l_done_r <= 1'b0;
            if (!l_busy_r && link_req_in) begin
                l_busy_r    <= 1'b1;
                l_req_tgl_r <= ~l_req_tgl_r;
                l_op_r      <= link_op_in;
                l_addr_r    <= link_addr_in;
            end else if (l_busy_r && (l_ack_s2_r != l_ack_seen_r)) begin
                l_busy_r     <= 1'b0;
                l_ack_seen_r <= l_ack_s2_r;
                l_done_r     <= 1'b1;
                l_grant_r    <= s_grant_r;
                l_rdata_r    <= s_rdata_r;
            end
        end
    end

    assign link_busy_out  = l_busy_r;
    assign link_done_out  = l_done_r;
    assign link_grant_out = l_grant_r;
    assign link_rdata_out = l_rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // System domain state
    zone_two_guard_pkg::guard_state_e st_r;
    logic        s_req_s1_r;
    logic        s_req_s2_r;
    logic        s_req_seen_r;
    logic [1:0]  op_r;
    logic [9:0]  addr_r;
    logic [255:0] zone_r;
    logic [127:0] counter_r;
    logic [15:0] test_r;
    logic [31:0] key_r;
    logic        fuse_r;
    logic        code_ok_r;
    logic        key_ok_r;
    logic        armed_r;
    logic        refused_r;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_req_s1_r <= 1'b0;
            s_req_s2_r <= 1'b0;
        end else begin
            s_req_s1_r <= l_req_tgl_r;
            s_req_s2_r <= s_req_s1_r;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r         <= zone_two_guard_pkg::ST_IDLE;
            s_req_seen_r <= 1'b0;
            op_r         <= 2'h0;
            addr_r       <= 10'h000;
        end else begin
            case (st_r)
                zone_two_guard_pkg::ST_IDLE: begin
                    if (s_req_s2_r != s_req_seen_r) begin
                        s_req_seen_r <= s_req_s2_r;
                        st_r         <= zone_two_guard_pkg::ST_LATCH;
                    end
                end
                zone_two_guard_pkg::ST_LATCH: begin
                    op_r   <= l_op_r;
                    addr_r <= l_addr_r;
                    st_r   <= zone_two_guard_pkg::ST_EXEC;
                end
                zone_two_guard_pkg::ST_EXEC: begin
                    st_r <= zone_two_guard_pkg::ST_IDLE;
                end
                default: begin
                    st_r <= zone_two_guard_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode and permission decision
    logic        exec;
    logic        mode2;
    logic        counting;
    logic        in_zone;
    logic        in_cnt;
    logic        in_test;
    logic [9:0]  zoff;
    logic [9:0]  coff;
    logic [9:0]  toff;
    logic        permit_wr;
    logic        permit_rd;
    logic        cnt_empty;
    logic        grant;
    logic        rbit;

    assign exec      = (st_r == zone_two_guard_pkg::ST_EXEC);
    assign mode2     = ~issuer_fuse_in;
    assign counting  = mode2 & fuse_r;
    assign in_zone   = (addr_r >= zone_two_guard_pkg::ZONE2_BASE) && (addr_r <= zone_two_guard_pkg::ZONE2_LAST);
    assign in_cnt    = (addr_r >= zone_two_guard_pkg::COUNTER_BASE) && (addr_r <= zone_two_guard_pkg::COUNTER_LAST);
    assign in_test   = (addr_r >= zone_two_guard_pkg::TEST_BASE) && (addr_r <= zone_two_guard_pkg::TEST_LAST);
    assign zoff      = addr_r - zone_two_guard_pkg::ZONE2_BASE;
    assign coff      = addr_r - zone_two_guard_pkg::COUNTER_BASE;
    assign toff      = addr_r - zone_two_guard_pkg::TEST_BASE;
    assign permit_wr = zone_r[WR_OFF[7:0]];
    assign permit_rd = zone_r[RD_OFF[7:0]];
    assign cnt_empty = (counter_r == '0);

    always_comb begin
        grant = 1'b0;
        rbit  = 1'b0;
        case (op_r)
            zone_two_guard_pkg::OP_READ: begin
                if (in_zone) begin
                    grant = permit_rd | code_ok_r;
                    rbit  = zone_r[zoff[7:0]];
                end else if (in_cnt) begin
                    grant = 1'b1;
                    rbit  = counter_r[coff[6:0]];
                end else if (in_test) begin
                    grant = 1'b1;
                    rbit  = test_r[toff[3:0]];
                end
            end
            zone_two_guard_pkg::OP_WRITE: begin
                if (in_zone) begin
                    grant = code_ok_r & (~mode2 | permit_wr);
                end else if (in_cnt) begin
                    grant = code_ok_r & counter_r[coff[6:0]];
                end else if (in_test) begin
                    grant = 1'b1;
                end
            end
            zone_two_guard_pkg::OP_ERASE: begin
                if (in_zone) begin
                    grant = code_ok_r & (~mode2 | (key_ok_r & (~counting | armed_r)));
                end else if (in_test) begin
                    grant = 1'b1;
                end
            end
            default: begin
                grant = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory effects
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            zone_r <= '1;
        end else if (exec && grant && in_zone) begin
            if (op_r == zone_two_guard_pkg::OP_WRITE) begin
                zone_r[zoff[7:0]] <= 1'b0;
            end else if (op_r == zone_two_guard_pkg::OP_ERASE) begin
                zone_r <= '1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            counter_r <= '1;
        end else if (exec && grant && in_cnt && (op_r == zone_two_guard_pkg::OP_WRITE)) begin
            counter_r[coff[6:0]] <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            test_r <= '1;
        end else if (exec && in_test && (op_r == zone_two_guard_pkg::OP_WRITE)) begin
            test_r[toff[3:0]] <= 1'b0;
        end else if (exec && in_test && (op_r == zone_two_guard_pkg::OP_ERASE)) begin
            test_r <= '1;
        end
    end

    // Answer words held stable until the next request
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_grant_r   <= 1'b0;
            s_rdata_r   <= 1'b0;
            s_ack_tgl_r <= 1'b0;
            refused_r   <= 1'b0;
        end else if (exec) begin
            s_grant_r   <= grant;
            s_rdata_r   <= grant & rbit;
            s_ack_tgl_r <= ~s_ack_tgl_r;
            refused_r   <= ~grant;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave, zero wait states
    logic        dp_write_r;
    logic [7:0]  dp_off_r;
    logic [31:0] rd_val;
    logic        addr_take;
    logic        wr_ctrl;
    logic        wr_key;
    logic        wr_check;
    logic        wr_fuse;
    logic        armed_set;
    logic [7:0]  ones;

    assign addr_take = hsel_in & hready_in & htrans_in[1];
    assign wr_ctrl   = dp_write_r & (dp_off_r == zone_two_guard_pkg::OFF_CTRL);
    assign wr_key    = dp_write_r & (dp_off_r == zone_two_guard_pkg::OFF_KEY);
    assign wr_check  = dp_write_r & (dp_off_r == zone_two_guard_pkg::OFF_KEY_CHECK);
    assign wr_fuse   = dp_write_r & (dp_off_r == zone_two_guard_pkg::OFF_FUSE);

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dp_write_r <= 1'b0;
            dp_off_r   <= 8'h00;
        end else begin
            dp_write_r <= addr_take & hwrite_in;
            dp_off_r   <= haddr_in[7:0];
        end
    end

    always_comb begin
        ones = 8'h00;
        for (int i = 0; i < int'(zone_two_guard_pkg::COUNTER_BITS); i++) begin
            ones = ones + {7'h00, counter_r[i]};
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        case (haddr_in[7:0])
            zone_two_guard_pkg::OFF_STATUS: begin
                rd_val[zone_two_guard_pkg::ST_CODE_OK_BIT]  = code_ok_r;
                rd_val[zone_two_guard_pkg::ST_KEY_OK_BIT]   = key_ok_r;
                rd_val[zone_two_guard_pkg::ST_MODE2_BIT]   = mode2;
                rd_val[zone_two_guard_pkg::ST_FUSE_BIT]    = fuse_r;
                rd_val[zone_two_guard_pkg::ST_ARMED_BIT]   = armed_r;
                rd_val[zone_two_guard_pkg::ST_REFUSED_BIT] = refused_r;
                rd_val[zone_two_guard_pkg::ST_COUNT_LSB +: 8] = ones;
            end
            zone_two_guard_pkg::OFF_FUSE: begin
                rd_val[zone_two_guard_pkg::FUSE_BIT] = fuse_r;
            end
            default: begin
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    // Key never reads back; it is a password
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (addr_take && !hwrite_in) begin
            hrdata_out <= rd_val;
        end
    end

    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            key_r <= zone_two_guard_pkg::KEY_RESET;
        end else if (wr_key && !mode2 && code_ok_r) begin
            key_r <= hwdata_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fuse_r <= zone_two_guard_pkg::FUSE_RESET;
        end else if (wr_fuse && !mode2) begin
            fuse_r <= hwdata_in[zone_two_guard_pkg::FUSE_BIT];
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            code_ok_r <= 1'b0;
        end else if (code_verify_in) begin
            code_ok_r <= 1'b1;
        end else if (wr_ctrl && hwdata_in[zone_two_guard_pkg::CTRL_END_SESSION]) begin
            code_ok_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            key_ok_r <= 1'b0;
        end else if (wr_check && (hwdata_in == key_r)) begin
            key_ok_r <= 1'b1;
        end else if (wr_ctrl && hwdata_in[zone_two_guard_pkg::CTRL_END_SESSION]) begin
            key_ok_r <= 1'b0;
        end
    end

    // Empty counter can never arm again
    assign armed_set = exec & grant & in_cnt & (op_r == zone_two_guard_pkg::OP_WRITE) & counting;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            armed_r <= 1'b0;
        end else if (armed_set) begin
            armed_r <= 1'b1;
        end else if ((exec && grant && in_zone && (op_r == zone_two_guard_pkg::OP_ERASE))
                     || (wr_ctrl && hwdata_in[zone_two_guard_pkg::CTRL_END_SESSION])) begin
            armed_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic zone_rd;
    logic zone_er;
    assign zone_rd = exec & in_zone & (op_r == zone_two_guard_pkg::OP_READ);
    assign zone_er = exec & in_zone & (op_r == zone_two_guard_pkg::OP_ERASE);

    a_read_refused: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        zone_rd && !permit_rd && !code_ok_r |=> !s_grant_r && !s_rdata_r)
        else $error("zone read granted without permit or verification");

    a_mode2_write: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        exec && in_zone && (op_r == zone_two_guard_pkg::OP_WRITE) && mode2 && !permit_wr |=> $stable(zone_r))
        else $error("level two zone write without permit bit");

    a_zone_erase_all: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        zone_er && code_ok_r && !mode2 |=> (zone_r == '1) && s_grant_r)
        else $error("level one zone erase did not clear whole zone");

    a_counter_no_erase: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        exec && in_cnt && (op_r == zone_two_guard_pkg::OP_ERASE) |=> $stable(counter_r) && !s_grant_r)
        else $error("erase counter was erased");

    a_empty_blocks: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        zone_er && counting && cnt_empty && !armed_r |=> !s_grant_r ##1 zone_r == $past(zone_r, 2))
        else $error("erase granted with empty counter");

    a_key_locked: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (mode2 || !code_ok_r) |=> $stable(key_r))
        else $error("erase key changed while locked");

    a_fuse_locked: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        mode2 |=> $stable(fuse_r))
        else $error("erase-limit fuse changed in mode two");

    a_test_open: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        exec && in_test && (op_r != 2'h3) |=> s_grant_r)
        else $error("test zone access refused");

    a_code_flag_set: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        code_verify_in |=> code_ok_r [*2])
        else $error("code verification did not set flag");

    a_answer_time: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        zone_er && mode2 && !key_ok_r |=> !s_grant_r ##[1:40] !l_busy_r)
        else $error("level two erase without key, or answer late");
endmodule
`default_nettype wire

// *** reader_model.sv ***
// Reader terminal model issuing single-bit link requests
`timescale 1ns/1ps
`default_nettype none
module reader_model (
    input  wire logic       link_clk_in,
    input  wire logic       busy_in,
    input  wire logic       done_in,
    output logic            req_out,
    output logic [1:0]      op_out,
    output logic [9:0]      addr_out
);
    initial begin
        req_out = 1'b0;
        op_out = 2'h0;
        addr_out = 10'h000;
    end
    // Request held until taken; released lines show the inverse, not stale data
    task automatic xfer(input logic [1:0] op, input logic [9:0] a, output logic ok);
        int n;
        n = 0;
        @(posedge link_clk_in);
        req_out <= 1'b1;
        op_out <= op;
        addr_out <= a;
        do @(posedge link_clk_in); while (busy_in !== 1'b0);
        req_out <= 1'b0;
        op_out <= ~op;
        addr_out <= ~a;
        do begin
            @(posedge link_clk_in);
            n++;
        end while (done_in !== 1'b1 && n < 20);
        ok = done_in;
    endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench: behavioural guard model compared with the design
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        sys_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, issuer = 1'b1, cv = 1'b0, hwrite = 1'b0;
    logic        hrdy, hresp, req, busy, done, grant, rdata;
    logic [1:0]  htrans = 2'h0, op;
    logic [9:0]  addr;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, q, key, rng = 32'h1a6b;
    int          miscompares = 0, tests_run = 0, code_ok, key_ok, fuse, armed, refd;
    bit          zone[256], cnt[128], tz[16];
    always #2.5 sys_clk = ~sys_clk;
    always #24 link_clk = ~link_clk;
    zone_two_access_guard i_dut (.sys_clk_in(sys_clk), .rst_in(rst), .hsel_in(1'b1), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
        .hreadyout_out(hrdy), .hresp_out(hresp), .hrdata_out(hrdata), .issuer_fuse_in(issuer),
        .code_verify_in(cv), .link_clk_in(link_clk), .link_req_in(req), .link_op_in(op),
        .link_addr_in(addr), .link_busy_out(busy), .link_done_out(done), .link_grant_out(grant),
        .link_rdata_out(rdata));
    reader_model i_rd (.link_clk_in(link_clk), .busy_in(busy), .done_in(done), .req_out(req),
        .op_out(op), .addr_out(addr));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("Compared %0d, mismatched %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Zero-wait slave, but the master still waits on hready, bounded
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do begin @(posedge sys_clk); n++; end while (hrdy !== 1'b1 && n < 20);
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge sys_clk); n++; end while (hrdy !== 1'b1 && n < 40);
        q = hrdata;
        check("hresp", {31'h0000_0000, hresp}, 32'h0000_0000);
        if (n >= 40) begin miscompares++; tally_and_finish(); end
    endtask
    task automatic status();
        int c;
        c = 0;
        foreach (cnt[i]) c += cnt[i];
        bus(1'b0, zone_two_guard_pkg::OFF_STATUS, 32'h0000_0000);
        check("status", q, {16'h0000, 8'(c), 2'h0, refd[0], armed[0], fuse[0], !issuer, key_ok[0], code_ok[0]});
        $display("Status test done after %0d checks", tests_run);
    endtask
    // Model of one link operation, then the same request on the design
    task automatic lop(input logic [1:0] o, input int a);
        logic ok;
        int   i, g, r, cnting;
        cnting = !issuer && fuse;
        g = 0;
        r = 0;
        i = a - 448;
        if (a >= 448 && a < 704) begin
            if (o == 0) g = zone[33] | code_ok;
            if (o == 1) g = code_ok && (issuer || zone[32]);
            if (o == 2) g = code_ok && (issuer || key_ok && (!cnting || armed));
            if (g && o == 0) r = zone[i];
            if (g && o == 1) zone[i] = 0;
            if (g && o == 2) begin zone = '{default: 1}; armed = 0; end
        end else if (a >= 704 && a < 832) begin
            i = a - 704;
            g = o == 0 || o == 1 && code_ok && cnt[i];
            r = o == 0 && cnt[i];
            if (g && o == 1) begin cnt[i] = 0; armed |= cnting; end
        end else if (a >= 832 && a < 848) begin
            i = a - 832;
            g = o != 3;
            r = o == 0 && tz[i];
            if (o == 1) tz[i] = 0;
            // Erase of any test bit restores the whole test zone
            if (o == 2) tz = '{default: 1};
        end
        refd = !g;
        i_rd.xfer(o, a[9:0], ok);
        if (ok !== 1'b1) begin miscompares++; tally_and_finish(); end
        check("grant", grant, g);
        if (o == 0) check("rdata", rdata, r);
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        issuer <= 1'b1;
        // Link side needs several of its own edges inside reset
        repeat (4) @(posedge link_clk);
        rst <= 1'b0;
        code_ok = 0;
        key_ok = 0;
        fuse = 1;
        armed = 0;
        refd = 0;
        zone = '{default: 1};
        cnt = '{default: 1};
        tz = '{default: 1};
        repeat (3) @(posedge link_clk);
    endtask
    task automatic verify();
        @(posedge sys_clk);
        cv <= 1'b1;
        @(posedge sys_clk);
        cv <= 1'b0;
        code_ok = 1;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        status();
        bus(1'b0, 8'h14, 32'h0000_0000);
        check("unmapped", q, 32'h0000_0000);
        lop(2'h1, 500);
        lop(2'h0, 500);
        key = xs();
        bus(1'b1, zone_two_guard_pkg::OFF_KEY, key);
        verify();
        bus(1'b1, zone_two_guard_pkg::OFF_KEY_CHECK, key);
        bus(1'b1, zone_two_guard_pkg::OFF_KEY, key);
        bus(1'b1, zone_two_guard_pkg::OFF_KEY_CHECK, key ^ 32'h0000_0001);
        status();
        lop(2'h1, 481);
        lop(2'h1, 600);
        bus(1'b1, zone_two_guard_pkg::OFF_CTRL, 32'h0000_0001);
        code_ok = 0;
        key_ok = 0;
        armed = 0;
        lop(2'h0, 600);
        lop(2'h1, 601);
        for (int k = 0; k < 9; k++) lop(2'(k % 3), 832 + int'(xs() % 16));
        verify();
        lop(2'h0, 600);
        lop(2'h2, 700);
        lop(2'h0, 481);
        lop(2'h2, 704);
        lop(2'h3, 832);
        bus(1'b1, zone_two_guard_pkg::OFF_FUSE, 32'h0000_0000);
        bus(1'b1, zone_two_guard_pkg::OFF_FUSE, 32'h0000_0001);
        @(posedge sys_clk) issuer <= 1'b0;
        bus(1'b1, zone_two_guard_pkg::OFF_FUSE, 32'h0000_0000);
        status();
        lop(2'h2, 500);
        bus(1'b1, zone_two_guard_pkg::OFF_KEY, ~key);
        bus(1'b1, zone_two_guard_pkg::OFF_KEY_CHECK, key);
        key_ok = 1;
        lop(2'h2, 500);
        lop(2'h1, 480);
        lop(2'h1, 490);
        for (int k = 0; k < 128; k++) begin
            lop(2'h1, 704 + k);
            lop(2'h2, 500);
        end
        lop(2'h2, 500);
        lop(2'h1, 704);
        status();
        do_reset();
        bus(1'b1, zone_two_guard_pkg::OFF_FUSE, 32'h0000_0000);
        fuse = 0;
        @(posedge sys_clk) issuer <= 1'b0;
        verify();
        bus(1'b1, zone_two_guard_pkg::OFF_KEY_CHECK, 32'h0000_0000);
        key_ok = 1;
        repeat (3) lop(2'h2, 450);
        status();
        tally_and_finish();
    end
endmodule
`default_nettype wire
